// ---- core/ebi_pkg.sv ----
// Constants, register map and state encoding for the external bus interface.
// Assumes a register port on MCLK and a separate bus clock that also leaves the chip.
// ****************************************************************
// Contract
// - drive 24-bit access address during accesses
// - 16-bit data; device drives on writes only (it also drives the address in the multiplexed latch cycle of reads)
// - multiplexed format: address on data, latch pulse
// - read strobe low while read in progress
// - single-write mode: one write strobe low
// - byte strobe mode: one write strobe per lane
// - single-write mode: lane enables on every access
// - wait request extends the access while held
// - four area selects, only accessed one low
// - external bus clock output on its pin
// - four 16-Mbyte areas, each 8 or 16 bit
// - per-area endian; separate and multiplexed formats
// ****************************************************************
package ebi_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_AREAS = 4;
  localparam int REG_AW = 3;
  localparam int STRB_MIN_DEF = 4;
  localparam int STRB_CNT_W = 4;

  // register indices
  localparam logic [REG_AW-1:0] REG_CTRL = 3'h0;
  localparam logic [REG_AW-1:0] REG_ADDR = 3'h1;
  localparam logic [REG_AW-1:0] REG_WDATA = 3'h2;
  localparam logic [REG_AW-1:0] REG_CMD = 3'h3;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h4;
  localparam logic [REG_AW-1:0] REG_RDATA = 3'h5;

  // control register fields
  localparam int CTRL_WIDE_LSB = 0;
  localparam int CTRL_BIG_LSB = 4;
  localparam int CTRL_MUX_BIT = 8;
  localparam int CTRL_BSTRB_BIT = 9;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

  // command register fields
  localparam int CMD_WR_BIT = 0;
  localparam int CMD_WORD_BIT = 1;
  localparam int CMD_AREA_LSB = 2;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAITED_BIT = 1;

  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_SETUP = 3'b001,
    B_ADDR = 3'b010,
    B_STRB = 3'b011,
    B_HOLD = 3'b100,
    B_DONE = 3'b101
  } ebi_state_e;
endpackage : ebi_pkg

// ---- core/ebi_top.sv ----
// External bus interface: register port on MCLK, pin-facing access engine on BUS_CLK.
// Assumes BUS_CLK is the external bus clock, free running, unrelated to MCLK.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module ebi_top import ebi_pkg::*; #(
  parameter int STRB_MIN = STRB_MIN_DEF
) (
  // clocks and reset
  input wire logic MCLK,
  input wire logic RST,
  input wire logic BUS_CLK,
  // register port
  input wire logic [REG_AW-1:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // external bus pins (data pins double as ext_muxed_addr_data)
  output logic EXT_BCLK,
  output logic [ADDR_W-1:0] EXT_ADDR_OUT,
  input wire logic [DATA_W-1:0] EXT_DATA_IO_I,
  output logic [DATA_W-1:0] EXT_DATA_IO_O,
  output logic EXT_DATA_IO_OE,
  output logic ADDR_LATCH,
  output logic READ_STROBE_N,
  output logic WRITE_STROBE_N,
  output logic [1:0] LANE_WRITE_STROBE_N,
  output logic [1:0] LANE_ENABLE_N,
  input wire logic WAIT_REQ_N,
  output logic [NUM_AREAS-1:0] AREA_SELECT_N
);

  if (STRB_MIN < 3 || STRB_MIN > 15) begin : g_chk
    $error("STRB_MIN must lie in 3..15");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [DATA_W-1:0] swap16(input logic [DATA_W-1:0] d);
    swap16 = {d[7:0], d[15:8]};
  endfunction

  // byte lanes used: {high, low}
  function automatic logic [1:0] lanes_of(input logic wide, input logic word,
                                          input logic a0, input logic big);
    if (!wide) lanes_of = 2'h1;
    else if (word) lanes_of = 2'h3;
    else lanes_of = (a0 ^ big) ? 2'h2 : 2'h1;
  endfunction

  // ****************************************************************
  // register side (MCLK)
  // ****************************************************************
  logic [CTRL_W-1:0] ctrl;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic req_wr;
  logic req_word;
  logic [1:0] req_area;
  logic busy;
  logic req_tgl;
  logic ack_s1, ack_s2, ack_s3;
  logic [DATA_W-1:0] rdata_reg;
  logic waited_reg;
  logic ack_seen;
  logic start_ok;
  // bus-side results, stable while the ack toggle crosses
  logic ack_tgl;
  logic [DATA_W-1:0] rd_acc;
  logic waited;

  assign ack_seen = ack_s2 ^ ack_s3;
  assign start_ok = REG_WR && REG_ADDR_IN == REG_CMD && !busy;

  // config and request words are frozen while an access is in flight
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (REG_WR && !busy) begin
      if (REG_ADDR_IN == REG_CTRL) ctrl <= REG_WDATA[CTRL_W-1:0];
      if (REG_ADDR_IN == REG_ADDR) addr_reg <= REG_WDATA[ADDR_W-1:0];
      // ports share the index names, so the indices are scoped
      if (REG_ADDR_IN == ebi_pkg::REG_WDATA) wdata_reg <= REG_WDATA[DATA_W-1:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      req_wr <= 1'b0;
      req_word <= 1'b0;
      req_area <= 2'h0;
      req_tgl <= 1'b0;
    end else if (start_ok) begin
      req_wr <= REG_WDATA[CMD_WR_BIT];
      req_word <= REG_WDATA[CMD_WORD_BIT];
      req_area <= REG_WDATA[CMD_AREA_LSB +: 2];
      req_tgl <= ~req_tgl;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      busy <= 1'b0;
      rdata_reg <= '0;
      waited_reg <= 1'b0;
    end else if (start_ok) begin
      busy <= 1'b1;
    end else if (ack_seen) begin
      busy <= 1'b0;
      rdata_reg <= rd_acc;
      waited_reg <= waited;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      case (REG_ADDR_IN)
        REG_CTRL: REG_RDATA <= 32'(ctrl);
        REG_ADDR: REG_RDATA <= 32'(addr_reg);
        ebi_pkg::REG_WDATA: REG_RDATA <= 32'(wdata_reg);
        REG_CMD: REG_RDATA <= 32'({req_area, req_word, req_wr});
        REG_STATUS: REG_RDATA <= 32'({waited_reg, busy});
        ebi_pkg::REG_RDATA: REG_RDATA <= 32'(rdata_reg);
        default: REG_RDATA <= '0;
      endcase
    end else begin
      REG_RDATA <= '0;
    end
  end

  // ****************************************************************
  // bus side (BUS_CLK)
  // ****************************************************************
  logic req_s1, req_s2, req_s3;
  logic wait_s1, wait_s2;
  logic [DATA_W-1:0] din_s1, din_s2;
  logic start;
  ebi_state_e state, next_state;
  logic [STRB_CNT_W-1:0] strb_cnt;
  logic cnt_done;
  logic phase;
  logic b_wr, b_word, b_wide, b_big, b_mux, b_bstrb;
  logic [1:0] b_area;
  logic [ADDR_W-1:0] b_addr;
  logic [DATA_W-1:0] b_wdata;
  logic two_phase;
  logic half_hi;
  logic [1:0] lanes;
  logic [DATA_W-1:0] wr_bus;
  logic [ADDR_W-1:0] phase_addr;
  logic cs_window;

  assign start = req_s2 ^ req_s3;
  assign cnt_done = strb_cnt >= STRB_CNT_W'(STRB_MIN - 1);
  assign two_phase = b_word && !b_wide;
  assign half_hi = phase ^ b_big;
  assign lanes = lanes_of(b_wide, b_word, b_addr[0], b_big);
  assign phase_addr = b_addr + ADDR_W'(phase);
  assign cs_window = state == B_ADDR || state == B_STRB || state == B_HOLD;

  always_comb begin
    if (b_wide && b_word) wr_bus = b_big ? swap16(b_wdata) : b_wdata;
    else if (two_phase) wr_bus = half_hi ? {2{b_wdata[15:8]}} : {2{b_wdata[7:0]}};
    else wr_bus = {2{b_wdata[7:0]}};
  end

  always_ff @(posedge BUS_CLK or posedge RST) begin
    if (RST) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      wait_s1 <= 1'b1;
      wait_s2 <= 1'b1;
      din_s1 <= '0;
      din_s2 <= '0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      wait_s1 <= WAIT_REQ_N;
      wait_s2 <= wait_s1;
      din_s1 <= EXT_DATA_IO_I;
      din_s2 <= din_s1;
    end
  end

  // request words are stable here because the register side is busy
  always_ff @(posedge BUS_CLK or posedge RST) begin
    if (RST) begin
      b_wr <= 1'b0;
      b_word <= 1'b0;
      b_wide <= 1'b0;
      b_big <= 1'b0;
      b_mux <= 1'b0;
      b_bstrb <= 1'b0;
      b_area <= 2'h0;
      b_addr <= '0;
      b_wdata <= '0;
    end else if (state == B_IDLE && start) begin
      b_wr <= req_wr;
      b_word <= req_word;
      b_wide <= ctrl[CTRL_WIDE_LSB + req_area];
      b_big <= ctrl[CTRL_BIG_LSB + req_area];
      b_mux <= ctrl[CTRL_MUX_BIT];
      b_bstrb <= ctrl[CTRL_BSTRB_BIT];
      b_area <= req_area;
      b_addr <= addr_reg;
      b_wdata <= wdata_reg;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      B_IDLE: if (start) next_state = B_SETUP;
      B_SETUP: next_state = B_ADDR;
      B_ADDR: next_state = B_STRB;
      B_STRB: if (cnt_done && wait_s2) next_state = B_HOLD;
      B_HOLD: next_state = (two_phase && !phase) ? B_SETUP : B_DONE;
      B_DONE: next_state = B_IDLE;
      default: next_state = B_IDLE;
    endcase
  end

  always_ff @(posedge BUS_CLK or posedge RST) begin
    if (RST) state <= B_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge BUS_CLK or posedge RST) begin
    if (RST) strb_cnt <= '0;
    else if (state != B_STRB) strb_cnt <= '0;
    else if (!cnt_done) strb_cnt <= strb_cnt + 1'b1;
  end

  always_ff @(posedge BUS_CLK or posedge RST) begin
    if (RST) phase <= 1'b0;
    else if (state == B_IDLE) phase <= 1'b0;
    else if (state == B_HOLD && next_state == B_SETUP) phase <= 1'b1;
  end

  always_ff @(posedge BUS_CLK or posedge RST) begin
    if (RST) begin
      EXT_ADDR_OUT <= '0;
      EXT_DATA_IO_O <= '0;
    end else if (state == B_SETUP) begin
      EXT_ADDR_OUT <= phase_addr;
      EXT_DATA_IO_O <= b_mux ? phase_addr[DATA_W-1:0] : wr_bus;
    end else if (state == B_ADDR) begin
      EXT_DATA_IO_O <= wr_bus;
    end
  end

  // read data is taken as the strobe ends, from the synchronised pins
  always_ff @(posedge BUS_CLK or posedge RST) begin
    if (RST) begin
      rd_acc <= '0;
      waited <= 1'b0;
      ack_tgl <= 1'b0;
    end else begin
      if (state == B_IDLE && start) begin
        rd_acc <= '0;
        waited <= 1'b0;
      end
      if (state == B_STRB && cnt_done && !wait_s2) waited <= 1'b1;
      if (state == B_STRB && next_state == B_HOLD && !b_wr) begin
        if (b_wide && b_word) rd_acc <= b_big ? swap16(din_s2) : din_s2;
        else if (two_phase && half_hi) rd_acc[15:8] <= din_s2[7:0];
        else if (b_wide) rd_acc[7:0] <= lanes[1] ? din_s2[15:8] : din_s2[7:0];
        else rd_acc[7:0] <= din_s2[7:0];
      end
      if (state == B_DONE) ack_tgl <= ~ack_tgl;
    end
  end

  // ****************************************************************
  // pin decode
  // ****************************************************************
  assign EXT_BCLK = BUS_CLK;
  assign EXT_DATA_IO_OE = (state == B_ADDR && b_mux) ||
                          (b_wr && (state == B_STRB || state == B_HOLD));
  assign ADDR_LATCH = state == B_ADDR && b_mux;
  assign READ_STROBE_N = !(state == B_STRB && !b_wr);
  assign WRITE_STROBE_N = !(state == B_STRB && b_wr && !b_bstrb);
  assign LANE_WRITE_STROBE_N = (state == B_STRB && b_wr && b_bstrb) ? ~lanes : 2'h3;
  assign LANE_ENABLE_N = (cs_window && !b_bstrb) ? ~lanes : 2'h3;
  assign AREA_SELECT_N = cs_window ? ~(NUM_AREAS'(1) << b_area) : '1;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge BUS_CLK); endclocking
  default disable iff (RST);

  a_addr_stable: assert property ((state == B_STRB) |-> EXT_ADDR_OUT == phase_addr)
    else $error("address pins differ from access address");
  a_data_dir: assert property (EXT_DATA_IO_OE |-> (b_wr || ADDR_LATCH))
    else $error("data pins driven during read strobe");
  a_ale_addr: assert property (ADDR_LATCH |-> b_mux && EXT_DATA_IO_OE &&
                               EXT_DATA_IO_O == phase_addr[DATA_W-1:0])
    else $error("latch pulse without address on data lines");
  a_read_strobe: assert property ($fell(READ_STROBE_N) |-> !READ_STROBE_N [*3])
    else $error("read strobe shorter than minimum");
  a_single_wr: assert property (!WRITE_STROBE_N |-> !b_bstrb && b_wr
                                && LANE_WRITE_STROBE_N == 2'h3)
    else $error("single write strobe in byte strobe mode");
  a_lane_wr: assert property (LANE_WRITE_STROBE_N != 2'h3 |->
                              b_bstrb && WRITE_STROBE_N && LANE_WRITE_STROBE_N == ~lanes)
    else $error("lane write strobe wrong");
  a_lane_en: assert property ((state == B_STRB && !b_bstrb) |->
                              LANE_ENABLE_N == ~lanes && LANE_ENABLE_N != 2'h3)
    else $error("lane enables missing during access");
  a_wait_hold: assert property ((state == B_STRB && !wait_s2) |=> state == B_STRB)
    else $error("strobe ended while wait requested");
  a_one_area: assert property ($onehot0(~AREA_SELECT_N))
    else $error("more than one area select low");
  a_cs_span: assert property ((!READ_STROBE_N || !WRITE_STROBE_N) |->
                              !AREA_SELECT_N[b_area] ##1 !AREA_SELECT_N[b_area])
    else $error("area select dropped around strobe");

  c_read: cover property (state == B_STRB && !b_wr ##1 state == B_HOLD);
  c_write: cover property (state == B_STRB && b_wr && b_bstrb ##1 state == B_HOLD);
  c_waited: cover property (state == B_STRB && cnt_done && !wait_s2);
  c_two_phase: cover property (state == B_HOLD && two_phase && !phase ##1 state == B_SETUP);

endmodule : ebi_top
`default_nettype wire

// ---- dv/ebi_ext_dev.sv ----
// Model of the external memory or peripheral sitting on the area selects.
// Assumes the bench feeds it the device pin outputs and takes the resolved data level.
`timescale 1ns/1ns
`default_nettype none
module ebi_ext_dev (
  // bus pins
  input wire logic bus_clk,
  input wire logic rst,
  input wire logic [3:0] cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] lane_wr_n,
  input wire logic dev_oe,
  input wire logic [15:0] dev_o,
  output logic wait_n,
  output logic [15:0] pins,
  // bench side
  input wire logic [15:0] rd_word,
  input wire logic [7:0] wait_len,
  output logic [15:0] wr_word
);
  logic [15:0] prev;
  logic [7:0] wcnt;
  logic sel_d;
  // ****************************************************************
  // pin level and wait source
  // ****************************************************************
  // released pins show the inverse of the last level
  always_comb begin
    if (dev_oe) pins = dev_o;
    else if (cs_n != 4'hf && !rd_n) pins = rd_word;
    else pins = ~prev;
  end
  assign wait_n = (wcnt == 8'h00);
  always_ff @(posedge bus_clk or posedge rst) begin
    if (rst) begin
      prev <= 16'h0000;
      wcnt <= 8'h00;
      sel_d <= 1'b0;
      wr_word <= 16'h0000;
    end else begin
      prev <= pins;
      sel_d <= (cs_n != 4'hf);
      if (cs_n != 4'hf && !sel_d && wait_len != 8'h00) wcnt <= wait_len;
      else if (wcnt != 8'h00) wcnt <= wcnt - 8'h01;
      if (!wr_n) wr_word <= dev_o;
      if (!lane_wr_n[0]) wr_word[7:0] <= dev_o[7:0];
      if (!lane_wr_n[1]) wr_word[15:8] <= dev_o[15:8];
    end
  end
endmodule // ebi_ext_dev
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the external bus interface.
// Assumes ebi_top and ebi_pkg compiled first; ebi_ext_dev stands on the pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ebi_pkg::*;
  localparam int S = 4;
  logic mclk = 0, rst = 1, bus_clk = 0, reg_wr_s = 0, reg_rd_s = 0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, rv;
  logic ebclk, oe, ale, rdn, wrn, wreq, s_oe;
  logic [23:0] addr, s_addr;
  logic [15:0] din, dout, s_ale, rd_word = 16'h0000, wr_word;
  logic [7:0] wait_len = 8'h00;
  logic [3:0] csn, s_cs;
  logic [1:0] lwn, be, s_be, s_lw;
  int slen, mismatches, n_compared;
  always #5 mclk = ~mclk;
  always #6 bus_clk = ~bus_clk;
  ebi_top #(.STRB_MIN(S)) i_dut (.MCLK(mclk), .RST(rst), .BUS_CLK(bus_clk),
    .REG_ADDR_IN(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr_s), .REG_RD(reg_rd_s),
    .REG_RDATA(reg_rdata), .EXT_BCLK(ebclk), .EXT_ADDR_OUT(addr), .EXT_DATA_IO_I(din),
    .EXT_DATA_IO_O(dout), .EXT_DATA_IO_OE(oe), .ADDR_LATCH(ale), .READ_STROBE_N(rdn),
    .WRITE_STROBE_N(wrn), .LANE_WRITE_STROBE_N(lwn), .LANE_ENABLE_N(be),
    .WAIT_REQ_N(wreq), .AREA_SELECT_N(csn));
  ebi_ext_dev i_dev (.bus_clk(bus_clk), .rst(rst), .cs_n(csn), .rd_n(rdn), .wr_n(wrn),
    .lane_wr_n(lwn), .dev_oe(oe), .dev_o(dout), .wait_n(wreq), .pins(din),
    .rd_word(rd_word), .wait_len(wait_len), .wr_word(wr_word));
  // ****************************************************************
  // strobe monitor and bus tasks
  // ****************************************************************
  always @(posedge bus_clk) begin
    if (!rdn || !wrn || lwn != 2'b11) begin
      slen <= slen + 1;
      s_cs <= csn;
      s_addr <= addr;
      s_be <= be;
      s_lw <= lwn;
      s_oe <= oe;
    end
    if (ale) s_ale <= dout;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reg_wr(input logic [REG_AW-1:0] idx, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= idx;
    reg_wdata <= d;
    reg_wr_s <= 1'b1;
    @(posedge mclk);
    reg_wr_s <= 1'b0;
  endtask
  task automatic reg_rd(input logic [REG_AW-1:0] idx, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= idx;
    reg_rd_s <= 1'b1;
    @(posedge mclk);
    reg_rd_s <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  // runs one access: area, word, write, address, write data
  task automatic access(input int ar, input bit wd, input bit wr, input logic [23:0] a,
                        input logic [15:0] d);
    int i;
    logic [31:0] st;
    reg_wr(REG_ADDR, {8'h00, a});
    reg_wr(REG_WDATA, {16'h0000, d});
    slen = 0;
    reg_wr(REG_CMD, 32'((ar << CMD_AREA_LSB) | (wd << CMD_WORD_BIT) | wr));
    st = 32'h1;
    for (i = 0; i < 100 && st[STAT_BUSY_BIT] !== 1'b0; i++) reg_rd(REG_STATUS, st);
    if (i == 100) begin
      chk("busy clear", 32'h0, 32'h1);
      summarize();
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    chk("idle pins", 32'hffc, {20'h0, rdn, wrn, lwn, be, csn, oe, ale});
    @(posedge bus_clk);
    #1 chk("bus clock high", 32'h1, {31'h0, ebclk});
    @(negedge bus_clk);
    #1 chk("bus clock low", 32'h0, {31'h0, ebclk});
    reg_rd(REG_CTRL, rv);
    chk("ctrl reset", 32'h0, rv);
    reg_rd(3'h7, rv);
    chk("unmapped read", 32'h0, rv);
  endtask
  task automatic t_read_areas;
    reg_wr(REG_CTRL, 32'h00f);
    for (int a = 0; a < 4; a++) begin
      rd_word = 16'h1234 + 16'(a);
      access(a, 1, 0, 24'h8a5c30 + 24'(2 * a), 16'h0000);
      chk("area select", {28'h0, ~(4'h1 << a)}, {28'h0, s_cs});
      chk("address", 32'h8a5c30 + 32'(2 * a), {8'h0, s_addr});
      chk("read strobe cycles", S, slen);
      chk("lane enables", 32'h0, {30'h0, s_be});
      chk("data released", 32'h0, {31'h0, s_oe});
      reg_rd(REG_RDATA, rv);
      chk("read data", 32'h1234 + 32'(a), rv);
    end
  endtask
  task automatic t_write_single;
    access(2, 1, 1, 24'h000102, 16'hc3a5);
    chk("write data", 32'hc3a5, {16'h0, wr_word});
    chk("write strobe cycles", S, slen);
    chk("lane strobes idle", 32'h3, {30'h0, s_lw});
    chk("data driven", 32'h1, {31'h0, s_oe});
    chk("lane enables", 32'h0, {30'h0, s_be});
  endtask
  task automatic t_narrow;
    reg_wr(REG_CTRL, 32'h000);
    access(0, 0, 1, 24'h000003, 16'h0077);
    chk("narrow lane", 32'h2, {30'h0, s_be});
    chk("narrow data", 32'h77, {24'h0, wr_word[7:0]});
    rd_word = 16'h00c4;
    access(0, 1, 0, 24'h000020, 16'h0000);
    chk("narrow word strobes", 2 * S, slen);
    chk("second byte address", 32'h21, {8'h0, s_addr});
    reg_rd(REG_RDATA, rv);
    chk("narrow word data", 32'hc4c4, rv);
  endtask
  task automatic t_byte_strobe;
    reg_wr(REG_CTRL, 32'h00f | (32'h1 << CTRL_BSTRB_BIT));
    access(0, 0, 1, 24'h000011, 16'h005a);
    chk("lane strobes", 32'h1, {30'h0, s_lw});
    chk("high lane data", 32'h5a, {24'h0, wr_word[15:8]});
    chk("lane enables off", 32'h3, {30'h0, s_be});
  endtask
  task automatic t_mux;
    reg_wr(REG_CTRL, 32'h00f | (32'h1 << CTRL_MUX_BIT));
    access(3, 1, 1, 24'h12abcd, 16'h0f0f);
    chk("latched address", 32'habcd, {16'h0, s_ale});
    chk("mux write data", 32'h0f0f, {16'h0, wr_word});
  endtask
  task automatic t_endian_wait;
    reg_wr(REG_CTRL, 32'h00f | (32'h2 << CTRL_BIG_LSB));
    rd_word = 16'h1357;
    wait_len = 8'h08;
    access(1, 1, 0, 24'h000040, 16'h0000);
    wait_len = 8'h00;
    chk("strobe stretched", 32'h1, {31'h0, slen > S});
    reg_rd(REG_STATUS, rv);
    chk("wait seen", 32'h1, {31'h0, rv[STAT_WAITED_BIT]});
    reg_rd(REG_RDATA, rv);
    chk("big endian word", 32'h5713, rv);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_read_areas();
    t_write_single();
    t_narrow();
    t_byte_strobe();
    t_mux();
    t_endian_wait();
    summarize();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    chk("run length", 32'h0, 32'h1);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
